// >>> core/phy_id_and_an_advertise_regs.sv
`timescale 1ns/1ns
`default_nettype none

`include "phy_mgmt_regs.svh"

module phy_id_and_an_advertise_regs
#(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  // Arbitrary identifier, model and revision values.
  parameter logic [23:0] ORG_ID = 24'h5a3c96,
  parameter logic [5:0] VENDOR_MODEL = 6'h2a,
  parameter logic [3:0] MODEL_REV = 4'h3
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic strap_fast_full_duplex,
  input wire logic strap_fast,
  input wire logic autoneg_complete,
  input wire logic full_duplex,
  input wire logic partner_pause,
  input wire logic partner_asym_pause,
  output logic [15:0] advertise_word,
  output logic [1:0] pause_resolution
);

  import phy_mgmt_pkg::*;

  phy_mgmt_pkg::mgmt_state_t s;
  phy_mgmt_pkg::mgmt_state_t next_s;
  logic mdc_s;
  logic mdio_s;
  logic strap_fd_s;
  logic strap_tx_s;
  logic mdc_rise;
  logic [15:0] adv_word;
  logic [15:0] ident_high;
  logic [15:0] ident_low;
  logic [15:0] status_word;
  logic [15:0] write_word;

  pin_sync sync_mdc
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin(mdc),
    .synced(mdc_s)
  );

  pin_sync sync_mdio
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin(mdio_in),
    .synced(mdio_s)
  );

  // Strap synchronisers keep running through reset so the strap level reaches the register.
  pin_sync sync_strap_fd
  (
    .ref_clk(ref_clk),
    .reset(1'b0),
    .pin(strap_fast_full_duplex),
    .synced(strap_fd_s)
  );

  pin_sync sync_strap_tx
  (
    .ref_clk(ref_clk),
    .reset(1'b0),
    .pin(strap_fast),
    .synced(strap_tx_s)
  );

  // The identifier drops its two top bits and splits across two registers.
  assign ident_high = ORG_ID[21:6];
  assign ident_low = {ORG_ID[5:0], VENDOR_MODEL, MODEL_REV};

  always_comb
  begin
    status_word = 16'h0000;
    status_word[`STATUS_AN_COMPLETE] = autoneg_complete;
  end

  // Reserved and unsupported bits are forced to zero on read.
  always_comb
  begin
    adv_word = 16'h0000;
    adv_word[`ADV_NEXT_PAGE] = s.next_page_request;
    adv_word[`ADV_RESERVED_14] = 1'b0;
    adv_word[`ADV_REMOTE_FAULT] = s.remote_fault_advertise;
    adv_word[`ADV_RESERVED_12] = 1'b0;
    adv_word[`ADV_ASYM_PAUSE] = s.asymmetric_pause_advertise;
    adv_word[`ADV_PAUSE] = s.pause_advertise;
    adv_word[`ADV_T4] = 1'b0;
    adv_word[`ADV_FAST_FD] = s.fast_full_duplex_ability;
    adv_word[`ADV_FAST] = s.fast_ability;
    adv_word[`ADV_TEN_FD] = s.ten_full_duplex_ability;
    adv_word[`ADV_TEN] = s.ten_ability;
    adv_word[`ADV_SEL_MSB:`ADV_SEL_LSB] = s.selector;
  end

  function automatic logic [15:0] read_word(input logic [4:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    if (addr == `REG_BASIC_STATUS)
      w = status_word;
    else if (addr == `REG_IDENT_HIGH)
      w = ident_high;
    else if (addr == `REG_IDENT_LOW)
      w = ident_low;
    else if (addr == `REG_ADVERTISE)
      w = adv_word;
    else
      w = 16'h0000;
    return w;
  endfunction

  assign write_word = {s.shift[14:0], mdio_s};
  assign mdc_rise = mdc_s & ~s.mdc_prev;

  always_comb
  begin
    next_s = s;
    next_s.mdc_prev = mdc_s;
    // Pause resolution: bit 1 enables transmit pause, bit 0 receive pause.
    next_s.pause_res = 2'h0;
    if (full_duplex)
    begin
      if (s.pause_advertise && partner_pause)
        next_s.pause_res = 2'h3;
      else if (!s.pause_advertise && s.asymmetric_pause_advertise && partner_pause && partner_asym_pause)
        next_s.pause_res = 2'h2;
      else if (s.pause_advertise && s.asymmetric_pause_advertise && !partner_pause && partner_asym_pause)
        next_s.pause_res = 2'h1;
      else
        next_s.pause_res = 2'h0;
    end
    if (mdc_rise)
    begin
      case (s.st)
        st_idle:
        begin
          if (mdio_s)
          begin
            if (s.cnt != `PREAMBLE_BITS)
              next_s.cnt = s.cnt + 6'd1;
          end
          else if (s.cnt == `PREAMBLE_BITS)
            next_s.st = st_start;
          else
            next_s.cnt = 6'd0;
        end
        st_start:
        begin
          next_s.cnt = 6'd0;
          next_s.st = mdio_s ? st_op : st_idle;
        end
        st_op:
        begin
          next_s.shift = write_word;
          next_s.cnt = s.cnt + 6'd1;
          if (s.cnt == `LAST_OP_BIT)
          begin
            next_s.cnt = 6'd0;
            next_s.op_read = (write_word[1:0] == `OP_READ);
            if (write_word[1:0] == `OP_READ || write_word[1:0] == `OP_WRITE)
              next_s.st = st_phy_addr;
            else
              next_s.st = st_idle;
          end
        end
        st_phy_addr:
        begin
          next_s.shift = write_word;
          next_s.cnt = s.cnt + 6'd1;
          if (s.cnt == `LAST_ADDR_BIT)
          begin
            next_s.cnt = 6'd0;
            next_s.addr_ok = (write_word[4:0] == PHY_ADDR);
            next_s.st = st_reg_addr;
          end
        end
        st_reg_addr:
        begin
          next_s.shift = write_word;
          next_s.cnt = s.cnt + 6'd1;
          if (s.cnt == `LAST_ADDR_BIT)
          begin
            next_s.cnt = 6'd0;
            next_s.reg_addr = write_word[4:0];
            next_s.st = st_turnaround;
          end
        end
        st_turnaround:
        begin
          next_s.cnt = s.cnt + 6'd1;
          if (s.cnt == 6'd0)
          begin
            if (s.op_read && s.addr_ok)
            begin
              next_s.mdio_oe = 1'b1;
              next_s.mdio_out = 1'b0;
              next_s.shift = read_word(s.reg_addr);
            end
          end
          else
          begin
            next_s.cnt = 6'd0;
            next_s.st = st_data;
            if (s.op_read && s.addr_ok)
            begin
              next_s.mdio_out = s.shift[15];
              next_s.shift = {s.shift[14:0], 1'b0};
            end
          end
        end
        st_data:
        begin
          next_s.cnt = s.cnt + 6'd1;
          if (s.op_read)
          begin
            next_s.mdio_out = s.shift[15];
            next_s.shift = {s.shift[14:0], 1'b0};
          end
          else
            next_s.shift = write_word;
          if (s.cnt == `LAST_DATA_BIT)
          begin
            next_s.cnt = 6'd0;
            next_s.st = st_idle;
            next_s.mdio_oe = 1'b0;
            next_s.mdio_out = 1'b0;
            // Only the advertisement register takes writes; others ignore them.
            if (!s.op_read && s.addr_ok && s.reg_addr == `REG_ADVERTISE)
            begin
              next_s.next_page_request = write_word[`ADV_NEXT_PAGE];
              next_s.remote_fault_advertise = write_word[`ADV_REMOTE_FAULT];
              next_s.asymmetric_pause_advertise = write_word[`ADV_ASYM_PAUSE];
              next_s.pause_advertise = write_word[`ADV_PAUSE];
              next_s.fast_full_duplex_ability = write_word[`ADV_FAST_FD];
              next_s.fast_ability = write_word[`ADV_FAST];
              next_s.ten_full_duplex_ability = write_word[`ADV_TEN_FD];
              next_s.ten_ability = write_word[`ADV_TEN];
              next_s.selector = write_word[`ADV_SEL_MSB:`ADV_SEL_LSB];
            end
          end
        end
        default:
        begin
          next_s.st = st_idle;
          next_s.cnt = 6'd0;
        end
      endcase
    end
    if (reset)
    begin
      next_s = '0;
      next_s.st = st_idle;
      next_s.fast_full_duplex_ability = strap_fd_s;
      next_s.fast_ability = strap_tx_s;
      next_s.ten_full_duplex_ability = `ADV_TEN_FD_RESET;
      next_s.ten_ability = `ADV_TEN_RESET;
      next_s.selector = `ADV_SELECTOR_RESET;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    s <= next_s;
  end

  assign mdio_out = s.mdio_out;
  assign mdio_oe = s.mdio_oe;
  assign advertise_word = adv_word;
  assign pause_resolution = s.pause_res;

endmodule // phy_id_and_an_advertise_regs

`default_nettype wire

// >>> core/phy_mgmt_pkg.sv
`default_nettype none

package phy_mgmt_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_op,
    st_phy_addr,
    st_reg_addr,
    st_turnaround,
    st_data
  } frame_state_t;

  typedef struct packed {
    frame_state_t st;
    logic [5:0] cnt;
    logic op_read;
    logic addr_ok;
    logic [4:0] reg_addr;
    logic [15:0] shift;
    logic mdc_prev;
    logic mdio_out;
    logic mdio_oe;
    logic next_page_request;
    logic remote_fault_advertise;
    logic asymmetric_pause_advertise;
    logic pause_advertise;
    logic fast_full_duplex_ability;
    logic fast_ability;
    logic ten_full_duplex_ability;
    logic ten_ability;
    logic [4:0] selector;
    logic [1:0] pause_res;
  } mgmt_state_t;

endpackage

`default_nettype wire

// >>> core/phy_mgmt_regs.svh
`ifndef PHY_MGMT_REGS_SVH
`define PHY_MGMT_REGS_SVH

// Register addresses on the management bus.
`define REG_BASIC_STATUS 5'h01
`define REG_IDENT_HIGH 5'h02
`define REG_IDENT_LOW 5'h03
`define REG_ADVERTISE 5'h04

// Field positions of the advertisement register.
`define ADV_NEXT_PAGE 15
`define ADV_RESERVED_14 14
`define ADV_REMOTE_FAULT 13
`define ADV_RESERVED_12 12
`define ADV_ASYM_PAUSE 11
`define ADV_PAUSE 10
`define ADV_T4 9
`define ADV_FAST_FD 8
`define ADV_FAST 7
`define ADV_TEN_FD 6
`define ADV_TEN 5
`define ADV_SEL_MSB 4
`define ADV_SEL_LSB 0

// Reset values of the advertisement register.
`define ADV_SELECTOR_RESET 5'h01
`define ADV_TEN_FD_RESET 1'h1
`define ADV_TEN_RESET 1'h1

// Field positions of the identification registers.
`define IDENT_ORG_LOW_MSB 15
`define IDENT_ORG_LOW_LSB 10
`define IDENT_MODEL_MSB 9
`define IDENT_MODEL_LSB 4
`define IDENT_REV_MSB 3
`define IDENT_REV_LSB 0

// Status register field position.
`define STATUS_AN_COMPLETE 5

// Pause resolution field positions in the control register.
`define CTRL_PAUSE_TX 13
`define CTRL_PAUSE_RX 12

// Management frame counts.
`define PREAMBLE_BITS 6'd32
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define LAST_OP_BIT 6'd1
`define LAST_ADDR_BIT 6'd4
`define LAST_DATA_BIT 6'd15

`endif

// >>> core/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pin,
  output logic synced
);

  logic stage1;

  // The first stage feeds only the second.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      stage1 <= 1'b0;
      synced <= 1'b0;
    end
    else
    begin
      stage1 <= pin;
      synced <= stage1;
    end
  end

endmodule // pin_sync

`default_nettype wire

// >>> verification/mgmt_master_model.sv
`timescale 1ns/1ns
`default_nettype none

module mgmt_master_model
(
  input wire logic ref_clk,
  input wire logic mdio,
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en
);
  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_en = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic bit_out(input logic b);
    mdc <= 1'b0;
    mdio_drv <= b;
    half();
    mdc <= 1'b1;
    half();
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic [17:0] tail;
    hdr = {32'hffffffff, 2'b01, op, phy, ra};
    tail = {2'b10, wd};
    tail[12] = 1'b0;
    rd = 16'h0000;
    mdio_en <= 1'b1;
    for (int i = 45; i >= 0; i--)
      bit_out(hdr[i]);
    if (op == 2'h2)
    begin
      mdio_en <= 1'b0;
      for (int i = 17; i >= 0; i--)
      begin
        mdc <= 1'b0;
        half();
        mdc <= 1'b1;
        if (i < 16)
          rd[i] = mdio;
        half();
      end
    end
    else
      for (int i = 17; i >= 0; i--)
        bit_out(tail[i]);
    mdc <= 1'b0;
    mdio_en <= 1'b0;
    half();
  endtask
endmodule // mgmt_master_model

`default_nettype wire

// >>> verification/phy_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none

module phy_regs_checker
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic strap_fast_full_duplex,
  input wire logic strap_fast,
  input wire logic full_duplex,
  input wire logic partner_pause,
  input wire logic partner_asym_pause,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [15:0] advertise_word,
  input wire logic [1:0] pause_resolution
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_ta_drive;
    !mdio_out ##1 mdio_oe[*8];
  endsequence

  property p_reserved_zero;
    advertise_word[14] == 1'b0 && advertise_word[12] == 1'b0 && advertise_word[9] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_reset_defaults;
    $fell(reset) |-> advertise_word[6:0] == 7'h61 && advertise_word[15:10] == 6'h00;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad default");

  property p_strap;
    $fell(reset) |-> advertise_word[8:7] == {strap_fast_full_duplex, strap_fast};
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded");

  property p_no_pause_half;
    !full_duplex |=> pause_resolution == 2'h0;
  endproperty
  a_no_pause_half: assert property (p_no_pause_half) else $error("pause in half duplex");

  property p_sym_pause;
    full_duplex && advertise_word[10] && partner_pause |=> pause_resolution == 2'h3;
  endproperty
  a_sym_pause: assert property (p_sym_pause) else $error("symmetric pause wrong");

  property p_asym_pause;
    full_duplex && advertise_word[11:10] == 2'h3 && !partner_pause && partner_asym_pause
      |=> pause_resolution == 2'h1;
  endproperty
  a_asym_pause: assert property (p_asym_pause) else $error("asymmetric pause wrong");

  property p_tx_pause;
    full_duplex && advertise_word[11:10] == 2'h2 && partner_pause && partner_asym_pause
      |=> pause_resolution == 2'h2;
  endproperty
  a_tx_pause: assert property (p_tx_pause) else $error("transmit pause wrong");

  property p_turnaround;
    $rose(mdio_oe) |-> s_ta_drive;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("read drive wrong");

  property p_stable_in_read;
    mdio_oe |-> $stable(advertise_word);
  endproperty
  a_stable_in_read: assert property (p_stable_in_read) else $error("change during read");
endmodule // phy_regs_checker

`default_nettype wire

// >>> verification/tb_phy_id_and_an_advertise_regs.sv
`timescale 1ns/1ns
`default_nettype none

module tb_phy_id_and_an_advertise_regs;
  // Arbitrary identifier, model and revision values.
  localparam logic [23:0] ORG = 24'hc3a5f0;
  localparam logic [5:0] VM = 6'h15;
  localparam logic [3:0] REV = 4'h9;
  logic ref_clk, reset, mdc, mdio, mdio_out, mdio_oe, m_drv, m_en;
  logic s_fd, s_tx, an_done, fd, p_pause, p_asym;
  logic [15:0] adv, rd;
  logic [1:0] pres;
  logic [21:0] rows [14];
  int n_fail, cmp_count;

  // The bus has a pull-up, so a released line reads 1.
  assign mdio = mdio_oe ? mdio_out : (m_en ? m_drv : 1'b1);

  phy_id_and_an_advertise_regs #(.PHY_ADDR(5'h01), .ORG_ID(ORG), .VENDOR_MODEL(VM), .MODEL_REV(REV)) u_dut
  (
    .ref_clk(ref_clk), .reset(reset), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .strap_fast_full_duplex(s_fd), .strap_fast(s_tx), .autoneg_complete(an_done), .full_duplex(fd),
    .partner_pause(p_pause), .partner_asym_pause(p_asym), .advertise_word(adv), .pause_resolution(pres)
  );

  mgmt_master_model u_mgr (.ref_clk(ref_clk), .mdio(mdio), .mdc(mdc), .mdio_drv(m_drv), .mdio_en(m_en));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic rst(input logic fdv, input logic txv);
    @(posedge ref_clk);
    reset <= 1'b1;
    s_fd <= fdv;
    s_tx <= txv;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pause(input logic [2:0] v, input logic [1:0] exp);
    @(posedge ref_clk);
    {fd, p_pause, p_asym} <= v;
    repeat (3) @(posedge ref_clk);
    chk({14'h0, pres}, {14'h0, exp});
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    reset = 1'b1;
    s_fd = 1'b1;
    s_tx = 1'b0;
    an_done = 1'b1;
    fd = 1'b0;
    p_pause = 1'b0;
    p_asym = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    rows = '{{1'b0, 5'h02, ORG[21:6]}, {1'b0, 5'h03, ORG[5:0], VM, REV},
             {1'b1, 5'h02, 16'hffff}, {1'b1, 5'h03, 16'h0000},
             {1'b0, 5'h02, ORG[21:6]}, {1'b0, 5'h03, ORG[5:0], VM, REV},
             {1'b1, 5'h04, 16'hffff}, {1'b0, 5'h04, 16'hadff},
             {1'b1, 5'h04, 16'h0000}, {1'b0, 5'h04, 16'h0000},
             {1'b1, 5'h04, 16'h4e02}, {1'b0, 5'h04, 16'h0c02},
             {1'b0, 5'h01, 16'h0020}, {1'b0, 5'h07, 16'h0000}};
    rst(1'b1, 1'b0);
    chk(adv, 16'h0161);
    foreach (rows[i])
    begin
      u_mgr.frame(rows[i][21] ? 2'h1 : 2'h2, 5'h01, rows[i][20:16], rows[i][15:0], rd);
      if (!rows[i][21])
        chk(rd, rows[i][15:0]);
    end
    chk(adv, 16'h0c02);
    u_mgr.frame(2'h2, 5'h1e, 5'h04, 16'h0000, rd);
    chk(rd, 16'hffff);
    u_mgr.frame(2'h1, 5'h1e, 5'h04, 16'h0000, rd);
    u_mgr.frame(2'h0, 5'h01, 5'h04, 16'h0000, rd);
    u_mgr.frame(2'h3, 5'h01, 5'h04, 16'h0000, rd);
    chk(adv, 16'h0c02);
    @(posedge ref_clk);
    an_done <= 1'b0;
    u_mgr.frame(2'h2, 5'h01, 5'h01, 16'h0000, rd);
    chk(rd, 16'h0000);
    pause(3'b111, 2'h3);
    pause(3'b101, 2'h1);
    pause(3'b011, 2'h0);
    an_done <= 1'b1;
    u_mgr.frame(2'h1, 5'h01, 5'h04, 16'h0801, rd);
    chk(adv, 16'h0801);
    pause(3'b111, 2'h2);
    rst(1'b0, 1'b1);
    chk(adv, 16'h00e1);
    close_out();
  end
endmodule // tb_phy_id_and_an_advertise_regs

bind phy_id_and_an_advertise_regs phy_regs_checker u_chk
(
  .ref_clk(ref_clk), .reset(reset), .strap_fast_full_duplex(strap_fast_full_duplex), .strap_fast(strap_fast),
  .full_duplex(full_duplex), .partner_pause(partner_pause), .partner_asym_pause(partner_asym_pause),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .advertise_word(advertise_word), .pause_resolution(pause_resolution)
);

`default_nettype wire
